// File: cdcam_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cdcam_host_model (
    input wire logic mclk,
    output logic access_active,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic rd_vld = 0;
    logic [7:0] exp_q[$];
    // Idle host, no frame open
    initial begin
        {access_active, reg_wr, reg_addr, reg_wdata} = 18'h00000;
    end
    task automatic frame(input logic on);
        @(negedge mclk);
        access_active = on;
    endtask
    // Released data turns to its inverse, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge mclk);
        reg_wr = 0;
        reg_wdata = ~d;
    endtask
    // Note the expected byte, then flag the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        repeat (2) @(negedge mclk);
        exp_q.push_back(e);
        rd_vld = 1;
        @(negedge mclk);
        rd_vld = 0;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: cdcam_params.svh
`ifndef CDCAM_PARAMS_SVH
`define CDCAM_PARAMS_SVH

// Register offsets
`define CDCAM_ADDR_DAY_OF_MONTH 8'h05
`define CDCAM_ADDR_DAY_OF_WEEK 8'h06
`define CDCAM_ADDR_MONTH_OF_YEAR 8'h07
`define CDCAM_ADDR_YEAR_OF_CENTURY 8'h08
`define CDCAM_ADDR_MINUTE_MATCH 8'h09

// Field masks of each register
`define CDCAM_MASK_DAY_OF_MONTH 8'h3f
`define CDCAM_MASK_DAY_OF_WEEK 8'h07
`define CDCAM_MASK_MONTH_OF_YEAR 8'h1f
`define CDCAM_MASK_YEAR_OF_CENTURY 8'hff
`define CDCAM_MASK_MINUTE_MATCH 8'hff
`define CDCAM_MINUTE_MATCH_DIS_BIT 7
`define CDCAM_MINUTE_VALUE_MASK 7'h7f

// Reset values
`define CDCAM_RST_DAY_OF_MONTH 8'h01
`define CDCAM_RST_DAY_OF_WEEK 8'h00
`define CDCAM_RST_MONTH_OF_YEAR 8'h01
`define CDCAM_RST_YEAR_OF_CENTURY 8'h00
`define CDCAM_RST_MINUTE_MATCH 8'h80

// Calendar limits, packed decimal
`define CDCAM_DAY_FIRST 8'h01
`define CDCAM_WEEKDAY_LAST 8'h06
`define CDCAM_MONTH_FIRST 8'h01
`define CDCAM_MONTH_FEB 8'h02
`define CDCAM_MONTH_APR 8'h04
`define CDCAM_MONTH_JUN 8'h06
`define CDCAM_MONTH_SEP 8'h09
`define CDCAM_MONTH_NOV 8'h11
`define CDCAM_MONTH_LAST 8'h12
`define CDCAM_YEAR_LAST 8'h99
`define CDCAM_DAYS_31 8'h31
`define CDCAM_DAYS_30 8'h30
`define CDCAM_DAYS_29 8'h29
`define CDCAM_DAYS_28 8'h28

`endif

// File: cdcam_pkg.sv
package cdcam_pkg;

    // Freeze state of the time counters
    typedef enum logic {
        CDCAM_RUN,
        CDCAM_HOLD
    } cdcam_freeze_e;

    typedef logic [7:0] cdcam_byte_t;

endpackage

// File: cdcam_top.sv
`include "cdcam_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cdcam_top
    import cdcam_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick_1hz,
    input wire logic access_active,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic day_carry,
    input wire logic [6:0] cur_minute,
    input wire logic match_flag_clear,
    output logic [7:0] reg_rdata,
    output logic time_tick,
    output logic match_flag
);

    // Packed decimal increment of a two-digit value
    function automatic cdcam_byte_t bcd_inc(input cdcam_byte_t v);
        cdcam_byte_t r;
        r = v;
        if (v[3:0] >= 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    // Leap year test on a packed decimal year, year zero included
    function automatic logic is_leap(input cdcam_byte_t y);
        logic r;
        r = 1'b0;
        if (!y[4]) begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return r;
    endfunction

    // Last day of a month in packed decimal
    function automatic cdcam_byte_t last_day(input cdcam_byte_t m, input cdcam_byte_t y);
        cdcam_byte_t r;
        r = `CDCAM_DAYS_31;
        if (m == `CDCAM_MONTH_FEB) begin
            r = is_leap(y) ? `CDCAM_DAYS_29 : `CDCAM_DAYS_28;
        end else if (m == `CDCAM_MONTH_APR || m == `CDCAM_MONTH_JUN ||
                     m == `CDCAM_MONTH_SEP || m == `CDCAM_MONTH_NOV) begin
            r = `CDCAM_DAYS_30;
        end
        return r;
    endfunction

    // Weekday step: Sunday follows the last code
    function automatic cdcam_byte_t wday_inc(input cdcam_byte_t w);
        cdcam_byte_t r;
        r = w + 8'h01;
        if (w >= `CDCAM_WEEKDAY_LAST) begin
            r = 8'h00;
        end
        return r;
    endfunction

    // One-hot address decode, shared by the write and read paths
    function automatic logic [4:0] reg_sel(input cdcam_byte_t a);
        logic [4:0] s;
        s = 5'h00;
        case (a)
            `CDCAM_ADDR_DAY_OF_MONTH: s = 5'h01;
            `CDCAM_ADDR_DAY_OF_WEEK: s = 5'h02;
            `CDCAM_ADDR_MONTH_OF_YEAR: s = 5'h04;
            `CDCAM_ADDR_YEAR_OF_CENTURY: s = 5'h08;
            `CDCAM_ADDR_MINUTE_MATCH: s = 5'h10;
            default: s = 5'h00;
        endcase
        return s;
    endfunction

    cdcam_freeze_e frz_reg, frz_next;
    logic pending_reg, pending_next;
    logic tick_out_reg, tick_out_next;
    cdcam_byte_t day_reg, day_next;
    cdcam_byte_t wday_reg, wday_next;
    cdcam_byte_t month_reg, month_next;
    cdcam_byte_t year_reg, year_next;
    cdcam_byte_t mmatch_reg, mmatch_next;
    cdcam_byte_t rdata_reg, rdata_next;
    logic flag_reg, flag_next;
    logic agree_prev_reg, agree_prev_next;
    logic agree;
    logic date_step;
    logic [4:0] sel;

    // Freeze control: a tick seen during an access waits for its end
    always_comb begin
        frz_next = frz_reg;
        pending_next = pending_reg;
        tick_out_next = 1'b0;
        case (frz_reg)
            CDCAM_RUN: begin
                if (access_active) begin
                    frz_next = CDCAM_HOLD;
                    pending_next = tick_1hz;
                end else begin
                    tick_out_next = tick_1hz;
                end
            end
            CDCAM_HOLD: begin
                if (access_active) begin
                    // only one kept; a second tick is lost
                    if (tick_1hz) begin
                        pending_next = 1'b1;
                    end
                end else begin
                    frz_next = CDCAM_RUN;
                    tick_out_next = pending_reg | tick_1hz;
                    pending_next = 1'b0;
                end
            end
            default: begin
                // Unreachable state; fall back to running
                frz_next = CDCAM_RUN;
                pending_next = 1'b0;
            end
        endcase
    end

    // Freeze state and released tick; time_tick leaves straight from its flop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            frz_reg <= CDCAM_RUN;
            pending_reg <= 1'b0;
            tick_out_reg <= 1'b0;
        end else begin
            frz_reg <= frz_next;
            pending_reg <= pending_next;
            tick_out_reg <= tick_out_next;
        end
    end

    // A carry lost here is not replayed; the hour counter stands still too
    // carries from the hour counter are ignored while frozen
    assign date_step = day_carry && !access_active;

    // Address decode for both register paths
    assign sel = reg_sel(reg_addr);

    // Calendar counters and host writes; a write beats a carry in the same cycle
    always_comb begin
        day_next = day_reg;
        wday_next = wday_reg;
        month_next = month_reg;
        year_next = year_reg;
        mmatch_next = mmatch_reg;
        if (date_step) begin
            // weekday counts 0 upward to 6, then back to 0
            wday_next = wday_inc(wday_reg);
            // Host values out of range are not checked; day and weekday roll at the next carry, month at the next month end
            // month end rolls day and month; the year steps only when month 12 rolls over
            if (day_reg >= last_day(month_reg, year_reg)) begin
                day_next = `CDCAM_DAY_FIRST;
                if (month_reg >= `CDCAM_MONTH_LAST) begin
                    month_next = `CDCAM_MONTH_FIRST;
                    year_next = (year_reg == `CDCAM_YEAR_LAST) ? 8'h00 : bcd_inc(year_reg);
                end else begin
                    month_next = bcd_inc(month_reg);
                end
            end else begin
                day_next = bcd_inc(day_reg);
            end
        end
        if (reg_wr && sel[0]) begin
            day_next = reg_wdata & `CDCAM_MASK_DAY_OF_MONTH;
        end
        if (reg_wr && sel[1]) begin
            wday_next = reg_wdata & `CDCAM_MASK_DAY_OF_WEEK;
        end
        if (reg_wr && sel[2]) begin
            month_next = reg_wdata & `CDCAM_MASK_MONTH_OF_YEAR;
        end
        if (reg_wr && sel[3]) begin
            year_next = reg_wdata & `CDCAM_MASK_YEAR_OF_CENTURY;
        end
        if (reg_wr && sel[4]) begin
            mmatch_next = reg_wdata & `CDCAM_MASK_MINUTE_MATCH;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // Reset date is the first day of year zero
            day_reg <= `CDCAM_RST_DAY_OF_MONTH;
            wday_reg <= `CDCAM_RST_DAY_OF_WEEK;
            month_reg <= `CDCAM_RST_MONTH_OF_YEAR;
            year_reg <= `CDCAM_RST_YEAR_OF_CENTURY;
            mmatch_reg <= `CDCAM_RST_MINUTE_MATCH;
        end else begin
            day_reg <= day_next;
            wday_reg <= wday_next;
            month_reg <= month_next;
            year_reg <= year_next;
            mmatch_reg <= mmatch_next;
        end
    end

    // low disable bit enables minute compare
    // with every compare disabled nothing can agree
    assign agree = !mmatch_reg[`CDCAM_MINUTE_MATCH_DIS_BIT] &&
                   (mmatch_reg[6:0] == (cur_minute & `CDCAM_MINUTE_VALUE_MASK));

    // Edge detect keeps a standing match from re-arming after a clear
    // Match flag; set wins over a clear in the same cycle
    always_comb begin
        agree_prev_next = agree;
        flag_next = flag_reg;
        // Clear first so a same-cycle set overrides it
        if (match_flag_clear) begin
            flag_next = 1'b0;
        end
        // set only on the first agreeing cycle
        if (agree && !agree_prev_reg) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
            agree_prev_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            agree_prev_reg <= agree_prev_next;
        end
    end

    // Reads are not stalled by the freeze, so a frame sees one fixed snapshot
    // Read data registered one cycle after the address; unmapped reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (sel[0]) begin
            rdata_next = day_reg;
        end
        if (sel[1]) begin
            rdata_next = wday_reg;
        end
        if (sel[2]) begin
            rdata_next = month_reg;
        end
        if (sel[3]) begin
            rdata_next = year_reg;
        end
        if (sel[4]) begin
            rdata_next = mmatch_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign time_tick = tick_out_reg;
    assign match_flag = flag_reg;

endmodule

`default_nettype wire

// File: cdcam_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cdcam_top_assertions (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick_1hz,
    input wire logic access_active,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [6:0] cur_minute,
    input wire logic match_flag_clear,
    input wire logic [7:0] reg_rdata,
    input wire logic time_tick,
    input wire logic match_flag
);
    logic pend_reg, pend_next, agr;
    logic [7:0] mm_reg, mm_next;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_comb begin
        pend_next = access_active & (pend_reg | tick_1hz);
        mm_next = (reg_wr && reg_addr == 8'h09) ? reg_wdata : mm_reg;
        agr = !mm_reg[7] && mm_reg[6:0] == cur_minute;
    end
    // Shadows reset with the block so the first edges stay quiet
    always_ff @(posedge mclk) begin
        pend_reg <= rst_n & pend_next;
        mm_reg <= rst_n ? mm_next : 8'h80;
    end
    sequence s_rel;
        !access_active && pend_reg;
    endsequence
    sequence s_pls;
        time_tick ##1 !time_tick;
    endsequence
    property p_tick; tick_1hz && !access_active && !$past(access_active) |=> time_tick; endproperty
    property p_frz; access_active |=> !time_tick; endproperty
    property p_def; s_rel |=> s_pls; endproperty
    property p_set; agr && !$past(agr) |=> match_flag; endproperty
    property p_hold; match_flag && !match_flag_clear |=> match_flag; endproperty
    property p_clr; match_flag_clear && !(agr && !$past(agr)) |=> !match_flag; endproperty
    property p_day; reg_addr == 8'h05 |=> reg_rdata[7:6] == 2'b00; endproperty
    property p_mon; reg_addr == 8'h07 |=> reg_rdata[7:5] == 3'b000; endproperty
    a_tick: assert property (p_tick) else $error("tick not released");
    a_frz: assert property (p_frz) else $error("tick while frozen");
    a_def: assert property (p_def) else $error("stored tick lost");
    a_set: assert property (p_set) else $error("match flag not set");
    a_hold: assert property (p_hold) else $error("match flag dropped");
    a_clr: assert property (p_clr) else $error("match flag not cleared");
    a_day: assert property (p_day) else $error("day spare bits set");
    a_mon: assert property (p_mon) else $error("month spare bits set");
endmodule
`default_nettype wire

// File: cdcam_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module cdcam_top_test;
    logic mclk, rst_n, tick_1hz, day_carry, match_flag_clear;
    logic [6:0] cur_minute, r;
    logic [7:0] reg_rdata, reg_addr, reg_wdata;
    logic access_active, reg_wr, time_tick, match_flag;
    logic [31:0] seed = 32'hd2bd;
    logic [63:0] tbl [5] = '{64'h04022806_29020400, 64'h00022901_01030002, 64'h99123105_01010006,
        64'h21043002_01052103, 64'h03022800_01030301};
    int num_errors = 0, checks = 0, cyc = 0, ticks = 0;
    always #20 mclk = ~mclk;
    cdcam_top dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick_1hz(tick_1hz),
        .access_active(access_active),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .day_carry(day_carry),
        .cur_minute(cur_minute),
        .match_flag_clear(match_flag_clear),
        .reg_rdata(reg_rdata),
        .time_tick(time_tick),
        .match_flag(match_flag)
    );
    cdcam_host_model host (
        .mclk(mclk),
        .access_active(access_active),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One-cycle pulse: 0 day carry, 1 tick, 2 flag clear
    task automatic pulse(input int k);
        @(negedge mclk);
        day_carry = (k == 0);
        tick_1hz = (k == 1);
        match_flag_clear = (k == 2);
        @(negedge mclk);
        {day_carry, tick_1hz, match_flag_clear} = 3'b000;
        repeat (3) @(negedge mclk);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watcher: oldest note against read data, ticks counted, hang cut short
    always @(posedge mclk) begin
        cyc++;
        ticks += time_tick;
        if (host.rd_vld)
            chk(reg_rdata, host.exp_q.pop_front());
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        {mclk, rst_n, tick_1hz, day_carry, match_flag_clear} = 5'h00;
        cur_minute = 7'h00;
        repeat (16) @(negedge mclk);
        rst_n = 1;
        for (int a = 5; a < 10; a++)
            host.rd(8'(a), 8'(40'h0100010080 >> (8 * (9 - a))));
        for (int a = 5; a < 9; a++) begin
            host.wr(8'(a), 8'hff);
            host.rd(8'(a), 8'(32'h3f071fff >> (8 * (8 - a))));
        end
        host.wr(8'h0a, 8'h5a);
        host.rd(8'h0a, 8'h00);
        $display("test registers done");
        // Load a date in one frame, carry one day, read it back in one frame
        for (int i = 0; i < 5; i++) begin
            host.frame(1);
            for (int j = 0; j < 4; j++)
                host.wr(8'(32'h08070506 >> (24 - 8 * j)), 8'(tbl[i] >> (56 - 8 * j)));
            host.frame(0);
            pulse(0);
            host.frame(1);
            for (int j = 0; j < 4; j++)
                host.rd(8'(32'h05070806 >> (24 - 8 * j)), 8'(tbl[i] >> (24 - 8 * j)));
            host.frame(0);
        end
        $display("test calendar done");
        host.frame(1);
        pulse(0);
        host.rd(8'h05, 8'h01);
        pulse(1);
        pulse(1);
        chk(8'(ticks), 8'h00);
        host.frame(0);
        repeat (4) @(negedge mclk);
        chk(8'(ticks), 8'h01);
        pulse(1);
        chk(8'(ticks), 8'h02);
        $display("test freeze done");
        seed = lfsr(seed);
        r = {3'(seed[7:0] % 6), 4'(seed[15:8] % 10)};
        cur_minute = r;
        repeat (3) @(negedge mclk);
        chk({7'h00, match_flag}, 8'h00);
        host.wr(8'h09, {1'b0, r});
        repeat (2) @(negedge mclk);
        chk({7'h00, match_flag}, 8'h01);
        pulse(2);
        chk({7'h00, match_flag}, 8'h00);
        cur_minute = r ^ 7'h01;
        @(negedge mclk);
        cur_minute = r;
        repeat (2) @(negedge mclk);
        chk({7'h00, match_flag}, 8'h01);
        host.wr(8'h09, {1'b1, r});
        pulse(2);
        cur_minute = r ^ 7'h01;
        @(negedge mclk);
        cur_minute = r;
        repeat (2) @(negedge mclk);
        chk({7'h00, match_flag}, 8'h00);
        $display("test match done");
        final_report();
    end
endmodule
bind cdcam_top cdcam_top_assertions u_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick_1hz(tick_1hz),
    .access_active(access_active),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .cur_minute(cur_minute),
    .match_flag_clear(match_flag_clear),
    .reg_rdata(reg_rdata),
    .time_tick(time_tick),
    .match_flag(match_flag)
);
`default_nettype wire
